/* File: lpmg_ext_src.sv */
// Purpose: external modulation voltage source model
// Assumes: level in mV, changed on the clock
// Notes:   requests above five volts are clipped, never passed on
`timescale 1ns/1ps

module lpmg_ext_src (
  // clock and request
  input  wire logic        clk_i,
  input  wire logic [15:0] req_mv_i,
  // connector side
  output logic      [15:0] mv_o = 16'h0000
);
  always @(posedge clk_i) begin
    mv_o <= (req_mv_i > 16'h1388) ? 16'h1388 : req_mv_i;
  end
endmodule

/* File: lpmg_pkg.sv */
// Purpose: constants and types for the led pulse modulation generator
// Assumes: 250 MHz clock, currents in mA, percentages in 0.1 % units
// Notes:   register map of the wishbone slave lives here
//
// Behaviour
// - pulse-width mode repeats rectangular pulses from 0.1 Hz to 20 kHz.
// - pulse-width high fraction programmable from 0.1 % to 99.9 % of period.
// - both pulse modes emit 1 to 1000 pulses or repeat without end.
// - a pulse count below one selects endless repetition.
// - pulse-width high level equals the programmed current, low level is zero.
// - pulse-width current is clamped between zero and the current limit.
// - both pulse modes copy the modulation as a ttl level to the connector.
// - on/off mode high and low times each 0.001 ms to 10 s.
// - on/off high level is brightness 0 to 100 % of the current limit; the code caps it at limit/10 % for limits under 1000 mA.
// - on/off period is high time plus low time, 0.05 Hz to 500 kHz.
// - waveform mode offers sine, square or triangle shapes.
// - waveform repetition frequency programmable from 20 Hz to 100 kHz.
// - upper level kept between lower and 100 %, lower between 0 % and upper.
// - levels are percent of current limit; amplitude is their difference.
// - waveform mode drives a ttl sync that toggles at the midpoint crossing.
// - external voltage scales at 800, 2000 or 400 mA/V by terminal and limit.

package lpmg_pkg;

  // ----------------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_LIMIT  = 8'h04;
  localparam logic [7:0] ADDR_CURR   = 8'h08;
  localparam logic [7:0] ADDR_PERIOD = 8'h0C;
  localparam logic [7:0] ADDR_HIGH   = 8'h10;
  localparam logic [7:0] ADDR_LOW    = 8'h14;
  localparam logic [7:0] ADDR_COUNT  = 8'h18;
  localparam logic [7:0] ADDR_WMAX   = 8'h1C;
  localparam logic [7:0] ADDR_WMIN   = 8'h20;
  localparam logic [7:0] ADDR_PHINC  = 8'h24;
  localparam logic [7:0] ADDR_EXTV   = 8'h28;
  localparam logic [7:0] ADDR_STATUS = 8'h2C;

  // ctrl fields
  localparam int CTRL_MODE_LSB  = 0;
  localparam int CTRL_SHAPE_LSB = 4;
  localparam int CTRL_TERM_BIT  = 8;
  localparam int CTRL_START_BIT = 31;

  typedef enum logic [2:0] {
    LPMG_MODE_OFF = 3'h0,
    LPMG_MODE_PWM = 3'h1,
    LPMG_MODE_PULSE = 3'h2,
    LPMG_MODE_WAVE = 3'h3,
    LPMG_MODE_EXT = 3'h4
  } lpmg_mode_t;

  typedef enum logic [1:0] {
    LPMG_SHAPE_SINE = 2'h0,
    LPMG_SHAPE_SQUARE = 2'h1,
    LPMG_SHAPE_TRIANGLE = 2'h2
  } lpmg_shape_t;

  // ----------------------------------------------------------------------
  // timing and scaling
  // ----------------------------------------------------------------------
  localparam longint CLK_HZ = 250000000;
  // pulse-width period limits, in hundredths of Hz
  localparam longint PWM_FMIN_CHZ = 10;
  localparam longint PWM_FMAX_CHZ = 2000000;
  localparam logic [31:0] PWM_PER_MAX =
    32'(CLK_HZ * 100 / PWM_FMIN_CHZ);
  localparam logic [31:0] PWM_PER_MIN =
    32'((CLK_HZ * 100 + PWM_FMAX_CHZ - 1) / PWM_FMAX_CHZ);
  // duty in 0.1 % steps
  localparam logic [9:0] DUTY_MIN = 10'h001;
  localparam logic [9:0] DUTY_MAX = 10'h3E7;
  localparam logic [9:0] PERMILLE = 10'h3E8;
  // on/off times in ns
  localparam longint TIME_MIN_NS = 1000;
  localparam longint TIME_MAX_NS = 10000000000;
  localparam longint CLK_NS = 4;
  localparam logic [31:0] PH_MIN =
    32'((TIME_MIN_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [31:0] PH_MAX = 32'(TIME_MAX_NS / CLK_NS);
  // counts
  localparam logic [10:0] COUNT_MAX = 11'h3E8;
  // waveform phase increment (32-bit accumulator), 20 Hz .. 100 kHz
  localparam longint WAVE_FMIN_HZ = 20;
  localparam longint WAVE_FMAX_HZ = 100000;
  localparam logic [31:0] PHINC_MIN =
    32'((WAVE_FMIN_HZ * 64'h1_0000_0000 + CLK_HZ - 1) / CLK_HZ);
  localparam logic [31:0] PHINC_MAX =
    32'(WAVE_FMAX_HZ * 64'h1_0000_0000 / CLK_HZ);
  // external scaling, mA per volt; input in mV
  localparam logic [15:0] EXT_MV_MAX = 16'h1388;
  localparam logic [15:0] COEF_LOW = 16'h0320;
  localparam logic [15:0] COEF_HIGH = 16'h07D0;
  localparam logic [15:0] COEF_SEC = 16'h0190;
  localparam logic [15:0] LIMIT_SPLIT_MA = 16'h0FA0;
  localparam logic [15:0] MV_PER_V = 16'h03E8;

endpackage

/* File: lpmg_top.sv */
// Purpose: led pulse modulation generator with wishbone registers
// Assumes: classic wishbone, 32-bit data, one clock, sync reset
// Notes:   current output in mA, ttl output for the modulation connector
//
// Decided for this implementation: the register offsets and the Wishbone register port.
`timescale 1ns/1ps

module lpmg_top #(
  parameter int CUR_W = 16
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // wishbone slave
  input  wire logic             cyc_i,
  input  wire logic             stb_i,
  input  wire logic             we_i,
  input  wire logic [7:0]       adr_i,
  input  wire logic [3:0]       sel_i,
  input  wire logic [31:0]      dat_i,
  output logic      [31:0]      dat_o,
  output logic                  ack_o,
  // led drive
  output logic      [CUR_W-1:0] primary_led_terminal_o,
  output logic      [CUR_W-1:0] secondary_led_terminal_o,
  // modulation_io_connector: input voltage in mV, ttl output
  input  wire logic [15:0]      modulation_io_connector_mv_i,
  output logic                  modulation_io_connector_o,
  output logic                  modulation_io_connector_oe_n_o
);

  if (CUR_W != 16) begin : g_bad_cur_w
    $error("lpmg_top: CUR_W must be 16");
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  logic [31:0] ctrl;
  logic [15:0] limit;
  logic [15:0] curr;
  logic [31:0] period;
  logic [31:0] high_t;
  logic [31:0] low_t;
  logic [31:0] count_set;
  logic [9:0]  wmax;
  logic [9:0]  wmin;
  logic [31:0] phinc;
  logic        start_p;
  logic        busy;
  logic        done;
  logic [10:0] pulses;
  logic [15:0] ext_ma;

  logic        hit;
  logic [31:0] rdata;
  logic [31:0] wdata;
  logic [31:0] old;

  logic [2:0]  mode;
  logic [1:0]  shape;
  logic        term2;

  assign hit   = cyc_i && stb_i && !ack_o;
  assign mode  = ctrl[lpmg_pkg::CTRL_MODE_LSB +: 3];
  assign shape = ctrl[lpmg_pkg::CTRL_SHAPE_LSB +: 2];
  assign term2 = ctrl[lpmg_pkg::CTRL_TERM_BIT];

  // byte lane merge against the current value
  assign old = (adr_i == lpmg_pkg::ADDR_CTRL)   ? ctrl :
               (adr_i == lpmg_pkg::ADDR_LIMIT)  ? {16'h0, limit} :
               (adr_i == lpmg_pkg::ADDR_CURR)   ? {16'h0, curr} :
               (adr_i == lpmg_pkg::ADDR_PERIOD) ? period :
               (adr_i == lpmg_pkg::ADDR_HIGH)   ? high_t :
               (adr_i == lpmg_pkg::ADDR_LOW)    ? low_t :
               (adr_i == lpmg_pkg::ADDR_COUNT)  ? count_set :
               (adr_i == lpmg_pkg::ADDR_WMAX)   ? {22'h0, wmax} :
               (adr_i == lpmg_pkg::ADDR_WMIN)   ? {22'h0, wmin} :
               (adr_i == lpmg_pkg::ADDR_PHINC)  ? phinc : 32'h0;

  genvar b;
  generate
    for (b = 0; b < 4; b = b + 1) begin : g_lane
      assign wdata[8*b +: 8] = sel_i[b] ? dat_i[8*b +: 8] : old[8*b +: 8];
    end
  endgenerate

  // ----------------------------------------------------------------------
  // clamps applied on write
  // ----------------------------------------------------------------------
  logic [31:0] per_c;
  logic [31:0] high_c;
  logic [31:0] low_c;
  logic [31:0] cnt_c;
  logic [31:0] inc_c;
  logic [9:0]  wmax_c;
  logic [9:0]  wmin_c;
  logic [15:0] curr_c;
  logic [10:0] cnt_f;
  logic [9:0]  duty_c;

  assign per_c = (wdata < lpmg_pkg::PWM_PER_MIN) ? lpmg_pkg::PWM_PER_MIN :
                 (wdata > lpmg_pkg::PWM_PER_MAX) ? lpmg_pkg::PWM_PER_MAX :
                 wdata;
  assign high_c = (wdata < lpmg_pkg::PH_MIN) ? lpmg_pkg::PH_MIN :
                  (wdata > lpmg_pkg::PH_MAX) ? lpmg_pkg::PH_MAX :
                  wdata;
  assign low_c = high_c;
  // signed count: below one means endless, stored as zero
  assign cnt_f = ($signed(wdata[21:0]) < 1) ? 11'h0 :
                 (wdata[21:0] > 22'(lpmg_pkg::COUNT_MAX)) ?
                 lpmg_pkg::COUNT_MAX : wdata[10:0];
  assign duty_c = (wdata[31:22] < lpmg_pkg::DUTY_MIN) ? lpmg_pkg::DUTY_MIN :
                  (wdata[31:22] > lpmg_pkg::DUTY_MAX) ?
                  lpmg_pkg::DUTY_MAX : wdata[31:22];
  assign cnt_c = {duty_c, 11'h0, cnt_f};
  assign inc_c = (wdata < lpmg_pkg::PHINC_MIN) ? lpmg_pkg::PHINC_MIN :
                 (wdata > lpmg_pkg::PHINC_MAX) ? lpmg_pkg::PHINC_MAX :
                 wdata;
  assign wmax_c = (wdata[9:0] > lpmg_pkg::PERMILLE) ? lpmg_pkg::PERMILLE :
                  (wdata[9:0] < wmin) ? wmin : wdata[9:0];
  assign wmin_c = (wdata[9:0] > wmax) ? wmax : wdata[9:0];
  assign curr_c = (wdata[15:0] > limit) ? limit : wdata[15:0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl      <= 32'h0;
      limit     <= 16'h0;
      curr      <= 16'h0;
      period    <= lpmg_pkg::PWM_PER_MAX;
      high_t    <= lpmg_pkg::PH_MIN;
      low_t     <= lpmg_pkg::PH_MIN;
      count_set <= 32'h0;
      wmax      <= lpmg_pkg::PERMILLE;
      wmin      <= 10'h000;
      phinc     <= lpmg_pkg::PHINC_MIN;
      start_p   <= 1'b0;
    end else begin
      start_p <= 1'b0;
      if (hit && we_i) begin
        if (adr_i == lpmg_pkg::ADDR_CTRL) begin
          ctrl    <= {1'b0, wdata[30:0]};
          start_p <= wdata[lpmg_pkg::CTRL_START_BIT];
        end else if (adr_i == lpmg_pkg::ADDR_LIMIT) begin
          limit <= wdata[15:0];
          if (curr > wdata[15:0]) curr <= wdata[15:0];
        end else if (adr_i == lpmg_pkg::ADDR_CURR) begin
          curr <= curr_c;
        end else if (adr_i == lpmg_pkg::ADDR_PERIOD) begin
          period <= per_c;
        end else if (adr_i == lpmg_pkg::ADDR_HIGH) begin
          high_t <= high_c;
        end else if (adr_i == lpmg_pkg::ADDR_LOW) begin
          low_t <= low_c;
        end else if (adr_i == lpmg_pkg::ADDR_COUNT) begin
          count_set <= cnt_c;
        end else if (adr_i == lpmg_pkg::ADDR_WMAX) begin
          wmax <= wmax_c;
        end else if (adr_i == lpmg_pkg::ADDR_WMIN) begin
          wmin <= wmin_c;
        end else if (adr_i == lpmg_pkg::ADDR_PHINC) begin
          phinc <= inc_c;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // wishbone answer: one cycle wait, unmapped reads zero
  // ----------------------------------------------------------------------
  assign rdata = (adr_i == lpmg_pkg::ADDR_STATUS) ?
                 {19'h0, pulses, done, busy} :
                 (adr_i == lpmg_pkg::ADDR_EXTV) ? {16'h0, ext_ma} : old;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0;
    end else begin
      ack_o <= hit;
      dat_o <= hit ? rdata : 32'h0;
    end
  end

  // ----------------------------------------------------------------------
  // pulse sequencer shared by pwm and on/off modes
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    LPMG_ST_IDLE = 2'h0,
    LPMG_ST_HIGH = 2'h1,
    LPMG_ST_LOW  = 2'h2
  } lpmg_state_t;

  lpmg_state_t state;
  lpmg_state_t next_state;
  logic [31:0] tmr;
  logic [31:0] hi_len;
  logic [31:0] lo_len;
  logic [41:0] prod;
  logic [31:0] pwm_hi;
  logic        pulse_mode;
  logic        tmr_end;
  logic        last;

  assign pulse_mode = (mode == 3'(lpmg_pkg::LPMG_MODE_PWM)) ||
                      (mode == 3'(lpmg_pkg::LPMG_MODE_PULSE));
  // duty in permille: product of period and duty, rounded down
  assign prod = period * {22'h0, count_set[31:22]};
  assign pwm_hi = 32'(prod / 42'(lpmg_pkg::PERMILLE));
  assign hi_len = (mode == 3'(lpmg_pkg::LPMG_MODE_PWM)) ?
                  ((pwm_hi == 32'h0) ? 32'h1 : pwm_hi) : high_t;
  // period is the sum of high and low phases
  assign lo_len = (mode == 3'(lpmg_pkg::LPMG_MODE_PWM)) ?
                  ((period > hi_len) ? period - hi_len : 32'h1) :
                  low_t;
  assign tmr_end = (tmr <= 32'h1);
  assign last = (count_set[10:0] != 11'h0) &&
                (pulses + 11'h1 >= count_set[10:0]);

  always_comb begin
    next_state = state;
    case (state)
      LPMG_ST_IDLE: begin
        if (start_p && pulse_mode) next_state = LPMG_ST_HIGH;
      end
      LPMG_ST_HIGH: begin
        if (tmr_end) next_state = LPMG_ST_LOW;
      end
      LPMG_ST_LOW: begin
        if (tmr_end) begin
          next_state = last ? LPMG_ST_IDLE : LPMG_ST_HIGH;
        end
      end
      default: next_state = LPMG_ST_IDLE;
    endcase
    if (!pulse_mode) next_state = LPMG_ST_IDLE;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state  <= LPMG_ST_IDLE;
      tmr    <= 32'h0;
      pulses <= 11'h0;
      done   <= 1'b0;
    end else begin
      state <= next_state;
      if (state != next_state) begin
        tmr <= (next_state == LPMG_ST_HIGH) ? hi_len : lo_len;
      end else begin
        tmr <= tmr - 32'h1;
      end
      if (start_p) begin
        pulses <= 11'h0;
        done   <= 1'b0;
      end else if (state == LPMG_ST_LOW && tmr_end) begin
        if (pulses != lpmg_pkg::COUNT_MAX) pulses <= pulses + 11'h1;
      end
      if (state == LPMG_ST_LOW && tmr_end && last) done <= 1'b1;
    end
  end

  assign busy = (state != LPMG_ST_IDLE);

  // ----------------------------------------------------------------------
  // waveform and external conversion
  // ----------------------------------------------------------------------
  logic        wave_run;
  logic [9:0]  wave_lvl;
  logic        wave_sync;
  logic [15:0] coef;
  logic [15:0] mv;
  logic [31:0] ext_full;

  assign wave_run = (mode == 3'(lpmg_pkg::LPMG_MODE_WAVE));

  lpmg_wave u_wave (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .run_i   (wave_run),
    .phinc_i (phinc),
    .shape_i (shape),
    .level_o (wave_lvl),
    .sync_o  (wave_sync)
  );

  // out-of-range source voltages are clipped at five volts
  assign mv = (modulation_io_connector_mv_i > lpmg_pkg::EXT_MV_MAX) ?
              lpmg_pkg::EXT_MV_MAX : modulation_io_connector_mv_i;
  assign coef = term2 ? lpmg_pkg::COEF_SEC :
                (limit > lpmg_pkg::LIMIT_SPLIT_MA) ? lpmg_pkg::COEF_HIGH :
                lpmg_pkg::COEF_LOW;
  assign ext_full = (mv * coef) / 32'(lpmg_pkg::MV_PER_V);
  assign ext_ma = (ext_full > 32'(limit)) ? limit : ext_full[15:0];

  // ----------------------------------------------------------------------
  // output level selection
  // ----------------------------------------------------------------------
  logic [25:0] pct_prod;
  logic [9:0]  wave_pct;
  logic [15:0] lvl_pwm;
  logic [15:0] lvl_pulse;
  logic [15:0] lvl_wave;
  logic [15:0] next_drive;
  logic        next_ttl;

  // curr holds current in pwm mode, brightness permille in on/off mode
  assign lvl_pwm = (state == LPMG_ST_HIGH) ? curr : 16'h0;
  assign lvl_pulse = (state == LPMG_ST_HIGH) ?
    16'((limit * ((curr > 16'(lpmg_pkg::PERMILLE)) ?
    16'(lpmg_pkg::PERMILLE) : curr)) / 32'(lpmg_pkg::PERMILLE)) :
    16'h0;
  // min + (max-min)*shape, all in permille of the limit
  assign wave_pct = 10'(wmin + 10'(((wmax - wmin) * wave_lvl) /
                    20'(lpmg_pkg::PERMILLE)));
  assign pct_prod = 26'(limit) * 26'(wave_pct);
  assign lvl_wave = 16'(pct_prod / 26'(lpmg_pkg::PERMILLE));

  assign next_drive =
    (mode == 3'(lpmg_pkg::LPMG_MODE_PWM))   ? lvl_pwm :
    (mode == 3'(lpmg_pkg::LPMG_MODE_PULSE)) ? lvl_pulse :
    (mode == 3'(lpmg_pkg::LPMG_MODE_WAVE))  ? lvl_wave :
    (mode == 3'(lpmg_pkg::LPMG_MODE_EXT))   ? ext_ma : 16'h0;
  assign next_ttl = pulse_mode ? (state == LPMG_ST_HIGH) :
                    wave_run && wave_sync;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      primary_led_terminal_o   <= 16'h0;
      secondary_led_terminal_o <= 16'h0;
      modulation_io_connector_o <= 1'b0;
    end else begin
      primary_led_terminal_o   <= term2 ? 16'h0 : next_drive;
      secondary_led_terminal_o <= term2 ? next_drive : 16'h0;
      modulation_io_connector_o <= next_ttl;
    end
  end

  // connector is an input in external mode, else driven
  assign modulation_io_connector_oe_n_o =
    (mode == 3'(lpmg_pkg::LPMG_MODE_EXT));

endmodule

/* File: lpmg_top_asserts.sv */
// Purpose: port checker for the modulation generator
// Assumes: full byte lanes on control and limit writes
// Notes:   mode and limit are shadowed from bus writes
`timescale 1ns/1ps

module lpmg_top_asserts #(
  parameter int CUR_W = 16
) (
  input wire logic             clk_i,
  input wire logic             rst_i,
  input wire logic             cyc_i,
  input wire logic             stb_i,
  input wire logic             we_i,
  input wire logic [7:0]       adr_i,
  input wire logic [3:0]       sel_i,
  input wire logic [31:0]      dat_i,
  input wire logic [31:0]      dat_o,
  input wire logic             ack_o,
  input wire logic [CUR_W-1:0] primary_led_terminal_o,
  input wire logic [CUR_W-1:0] secondary_led_terminal_o,
  input wire logic [15:0]      modulation_io_connector_mv_i,
  input wire logic             modulation_io_connector_o,
  input wire logic             modulation_io_connector_oe_n_o
);
  // ---------------------------------------------------------------
  // shadow state
  // ---------------------------------------------------------------
  logic [2:0]       mode;
  logic [15:0]      limit;
  logic [CUR_W-1:0] led;
  logic             wr;
  assign wr = cyc_i & stb_i & we_i & !ack_o;
  assign led = primary_led_terminal_o | secondary_led_terminal_o;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode <= 3'h0;
      limit <= 16'h0000;
    end else if (wr && adr_i == lpmg_pkg::ADDR_CTRL) begin
      mode <= dat_i[2:0];
    end else if (wr && adr_i == lpmg_pkg::ADDR_LIMIT) begin
      limit <= dat_i[15:0];
    end
  end

  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_ack_next: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("ack missing after request");
  chk_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  chk_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
    else $error("ack without request");
  chk_one_terminal: assert property (
    !(primary_led_terminal_o != 0 && secondary_led_terminal_o != 0))
    else $error("both terminals driven");
  chk_ttl_copy: assert property (
    (mode == 3'h1 || mode == 3'h2) && $past(mode, 4) == mode
    |-> modulation_io_connector_o == (led != 0))
    else $error("ttl copy differs from drive");
  chk_oe_mode: assert property (
    modulation_io_connector_oe_n_o == (mode == 3'h4))
    else $error("connector direction wrong");
  chk_pwm_ceiling: assert property (
    mode == 3'h1 |-> 32'(led) <= 32'(limit))
    else $error("pulse current above limit");
  chk_off_quiet: assert property (
    mode == 3'h0 && $past(mode) == 3'h0 && $past(mode, 2) == 3'h0
    |-> led == 0 && !modulation_io_connector_o)
    else $error("output active while off");
  chk_ext_ceiling: assert property (
    mode == 3'h4 && $past(mode, 3) == 3'h4 |-> 32'(led) <= 32'(limit))
    else $error("external current above limit");
  chk_wave_ceiling: assert property (
    mode == 3'h3 |-> 32'(led) <= 32'(limit))
    else $error("waveform above limit");

  cov_read: cover property (ack_o && !we_i);
  cov_pwm_on: cover property (mode == 3'h1 && led != 0);
  cov_ext_on: cover property (mode == 3'h4 && led != 0);
endmodule

bind lpmg_top lpmg_top_asserts #(.CUR_W(CUR_W)) u_lpmg_top_asserts (.*);

/* File: lpmg_top_test.sv */
// Purpose: self-checking bench for the modulation generator
// Assumes: one ack per request, outputs sampled at the falling edge
// Notes:   partner model drives the external modulation voltage
`timescale 1ns/1ps

module lpmg_top_test;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'hF;
  logic [31:0] dat = 32'h0;
  logic [31:0] rdat;
  logic        ack;
  logic [15:0] pri, sec, mv;
  logic [15:0] req_mv = 16'h0000;
  logic        ttl, oen;
  int          n_errors = 0;
  int          check_count = 0;
  int          pulses, hi, lvl, mn, mx, syn, fh, r2;

  always #2 clk_i = ~clk_i;

  lpmg_top u_lpmg_top (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat),
    .dat_o(rdat), .ack_o(ack), .primary_led_terminal_o(pri),
    .secondary_led_terminal_o(sec), .modulation_io_connector_mv_i(mv),
    .modulation_io_connector_o(ttl),
    .modulation_io_connector_oe_n_o(oen));
  lpmg_ext_src u_lpmg_ext_src (.clk_i(clk_i), .req_mv_i(req_mv),
    .mv_o(mv));

  // ---------------------------------------------------------------
  // tasks and model
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %0d exp %0d", $time, got, exp);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  // pulse count, first high length, level, span, ttl toggles
  task automatic obs(input int n);
    int cur, prev, run;
    logic pt;
    prev = 0;
    run = 0;
    pt = ttl;
    {pulses, hi, lvl, mx, syn, r2} = '0;
    mn = 99999;
    fh = -1;
    for (int i = 0; i < n; i++) begin
      @(negedge clk_i);
      cur = int'(pri) + int'(sec);
      if (cur != 0 && prev == 0) pulses++;
      if (cur != 0 && prev == 0 && pulses == 2) r2 = i;
      if (cur != 0 && fh < 0) fh = i;
      if (cur != 0) run++;
      if (cur != 0) lvl = cur;
      if (cur == 0 && prev != 0 && hi == 0) hi = run;
      mn = (cur < mn) ? cur : mn;
      mx = (cur > mx) ? cur : mx;
      if (ttl !== pt) syn++;
      pt = ttl;
      prev = cur;
    end
  endtask

  function automatic int ext_ma(int v, int t, int lim);
    int c;
    v = (v > 5000) ? 5000 : v;
    c = t ? 400 : ((lim > 4000) ? 2000 : 800);
    return (v * c / 1000 > lim) ? lim : v * c / 1000;
  endfunction

  task automatic finish_test;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge clk_i);
    n_errors++;
    finish_test();
  end

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    logic [31:0] q;
    int v, lim, t;
    void'($urandom(32'hd19f));
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    // unmapped place reads zero
    wr(8'h40, 32'hFFFFFFFF);
    wb(1'b0, 8'h40, 32'h0, q);
    chk(q, 32'h0);
    // count and duty clamping
    wr(lpmg_pkg::ADDR_COUNT, 32'h000005DC);
    wb(1'b0, lpmg_pkg::ADDR_COUNT, 32'h0, q);
    chk(q[10:0], 32'd1000);
    chk(q[31:22], 32'd1);
    wr(lpmg_pkg::ADDR_COUNT, 32'hFFFFFFFF);
    wb(1'b0, lpmg_pkg::ADDR_COUNT, 32'h0, q);
    chk(q[10:0], 32'd0);
    chk(q[31:22], 32'd999);
    // pulse-width burst of two at the shortest period
    wr(lpmg_pkg::ADDR_LIMIT, 32'd1000);
    wr(lpmg_pkg::ADDR_CURR, 32'd2000);
    wb(1'b0, lpmg_pkg::ADDR_CURR, 32'h0, q);
    chk(q, 32'd1000);
    wr(lpmg_pkg::ADDR_PERIOD, 32'd100);
    wr(lpmg_pkg::ADDR_COUNT, (32'd500 << 22) | 32'd2);
    wr(lpmg_pkg::ADDR_CTRL, 32'h80000001);
    obs(26000);
    chk(pulses, 2);
    chk(r2 - fh, 12500);
    chk((hi >= 6249 && hi <= 6251), 1);
    chk(lvl, 1000);
    chk(fh <= 3, 1);
    obs(200);
    chk(mx, 0);
    wb(1'b0, lpmg_pkg::ADDR_STATUS, 32'h0, q);
    chk(q[12:1], 32'd5);
    wb(1'b0, lpmg_pkg::ADDR_CTRL, 32'h0, q);
    chk(q, 32'h1);
    // on/off burst, brightness relative to the limit
    wr(lpmg_pkg::ADDR_LIMIT, 32'd2000);
    wr(lpmg_pkg::ADDR_CURR, 32'd500);
    wr(lpmg_pkg::ADDR_HIGH, 32'd100);
    wr(lpmg_pkg::ADDR_LOW, 32'd300);
    wr(lpmg_pkg::ADDR_COUNT, 32'd3);
    wr(lpmg_pkg::ADDR_CTRL, 32'h80000002);
    obs(2000);
    chk(pulses, 3);
    chk(hi, 250);
    chk(r2 - fh, 550);
    chk(lvl, 1000);
    wr(lpmg_pkg::ADDR_COUNT, 32'd0);
    wr(lpmg_pkg::ADDR_CTRL, 32'h80000002);
    obs(3000);
    chk(pulses >= 5, 1);
    wr(lpmg_pkg::ADDR_CTRL, 32'h0);
    // waveform shapes between 30 and 70 percent
    wr(lpmg_pkg::ADDR_LIMIT, 32'd1000);
    wr(lpmg_pkg::ADDR_WMAX, 32'd700);
    wr(lpmg_pkg::ADDR_WMIN, 32'd800);
    wb(1'b0, lpmg_pkg::ADDR_WMIN, 32'h0, q);
    chk(q, 32'd700);
    wr(lpmg_pkg::ADDR_WMIN, 32'd300);
    wr(lpmg_pkg::ADDR_PHINC, 32'hFFFFFFFF);
    wb(1'b0, lpmg_pkg::ADDR_PHINC, 32'h0, q);
    chk(q, lpmg_pkg::PHINC_MAX);
    for (int s = 0; s < 3; s++) begin
      wr(lpmg_pkg::ADDR_CTRL, 32'h80000003 | (32'(s) << 4));
      repeat (8) @(posedge clk_i);
      obs(3000);
      chk(mn >= 298 && mx <= 702, 1);
      chk(mn <= 310 && mx >= 690, 1);
      chk(syn >= 2, 1);
    end
    // external voltage scaling on both terminals
    for (int i = 0; i < 3; i++) begin
      t = (i == 2);
      lim = (i == 0) ? 3000 : ((i == 1) ? 5000 : 2000);
      v = $urandom_range(0, 6000);
      req_mv <= 16'(v);
      wr(lpmg_pkg::ADDR_CTRL, 32'h0);
      wr(lpmg_pkg::ADDR_LIMIT, 32'(lim));
      wr(lpmg_pkg::ADDR_CTRL, 32'h4 | (32'(t) << 8));
      repeat (8) @(posedge clk_i);
      chk(t ? sec : pri, 32'(ext_ma(v, t, lim)));
      chk(t ? pri : sec, 32'h0);
      chk(oen, 32'h1);
      wb(1'b0, lpmg_pkg::ADDR_EXTV, 32'h0, q);
      chk(q, 32'(ext_ma(v, t, lim)));
    end
    finish_test();
  end
endmodule

/* File: lpmg_wave.sv */
// Purpose: waveform shape generator from a phase accumulator
// Assumes: shape in 0.1 % of span, output level 0..1000
// Notes:   sine is a piecewise-parabolic approximation, no table
`timescale 1ns/1ps

module lpmg_wave (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // control
  input  wire logic        run_i,
  input  wire logic [31:0] phinc_i,
  input  wire logic [1:0]  shape_i,
  // result
  output logic      [9:0]  level_o,
  output logic             sync_o
);

  logic [31:0] phase;
  logic [9:0]  tri_lvl;
  logic [9:0]  sq_lvl;
  logic [9:0]  sin_lvl;
  logic [9:0]  next_level;
  logic [19:0] x;
  logic [19:0] par;

  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i) begin
      phase <= 32'h0;
    end else begin
      phase <= phase + phinc_i;
    end
  end

  // triangle: 0 at phase 0, peak at half
  assign x = {10'h0, (phase[31] ? ~phase[30:21] : phase[30:21])};
  assign tri_lvl = 10'((x * 20'h003E8) >> 10);
  assign sq_lvl  = phase[31] ? 10'h000 : lpmg_pkg::PERMILLE;
  // parabola 1-(1-t)^2 on the rising half gives a smooth bump
  assign par = 20'((20'h003FF - x) * (20'h003FF - x) >> 10);
  assign sin_lvl = 10'(((20'h003FF - par) * 20'h003E8) >> 10);

  assign next_level = (shape_i == 2'h0) ? sin_lvl :
                      (shape_i == 2'h1) ? sq_lvl : tri_lvl;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      level_o <= 10'h000;
      sync_o  <= 1'b0;
    end else begin
      level_o <= next_level;
      // high above midpoint, so it toggles at each 50 % crossing
      sync_o  <= run_i && (next_level >= 10'h1F4);
    end
  end

endmodule
